/* File: rtl/asram_host.sv */
// Overview of operation
// - Read: write enable high, output enable low.
// - Write starts when all controls active.
// - Any control going inactive ends write.
// - Data set up 25 ns before write end.
// - Strobe covers setup plus float delay.
// - Write strobe at least 35 ns.
// - Address stable 35 ns before write end.
// - Address valid at start, zero hold.
// - Address before or with chip-select fall.
// - Chip enables always at definite levels.
`include "asram_map.svh"
module asram_host
  import asram_pkg::*;
#(
  parameter int            ADDR_W  = `ASRAM_ADDR_W,
  parameter int            DATA_W  = `ASRAM_DATA_W,
  parameter asram_wr_end_e WR_END  = ASRAM_END_WE
) (
  input  wire logic              clock,
  input  wire logic              arst_n,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic [1:0]        req_lanes,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic                   chip_en1_n,
  output logic                   chip_en2,
  output logic                   write_en_n,
  output logic                   out_en_n,
  output logic                   upper_lane_en_n,
  output logic                   lower_lane_en_n,
  output logic [DATA_W-1:0]      data_out,
  output logic                   data_oe_n,
  input  wire logic [DATA_W-1:0] data_in
);
  localparam int TW = 4;
  // Least times round up to whole cycles, plus one cycle for the read wait
  localparam int RD_CYC   = (`ASRAM_ADDR_ACCESS_TIME_NS + `ASRAM_CLK_PERIOD_NS - 1)
                            / `ASRAM_CLK_PERIOD_NS + 1;
  localparam int PWE_NS   = (`ASRAM_WRITE_STROBE_WIDTH_NS >
                             (`ASRAM_WRITE_DATA_SETUP_NS + `ASRAM_WRITE_FLOAT_DELAY_NS))
                            ? `ASRAM_WRITE_STROBE_WIDTH_NS
                            : (`ASRAM_WRITE_DATA_SETUP_NS + `ASRAM_WRITE_FLOAT_DELAY_NS);
  localparam int WR_CYC   = (PWE_NS + `ASRAM_CLK_PERIOD_NS - 1) / `ASRAM_CLK_PERIOD_NS;
  localparam int REC_NS   = (`ASRAM_OE_FLOAT_DELAY_NS > `ASRAM_ADDR_CHANGE_HOLD_NS)
                            ? `ASRAM_OE_FLOAT_DELAY_NS : `ASRAM_ADDR_CHANGE_HOLD_NS;
  localparam int REC_CYC  = (REC_NS + `ASRAM_CLK_PERIOD_NS - 1) / `ASRAM_CLK_PERIOD_NS;

  asram_state_e          st_q, st_d;
  logic [ADDR_W-1:0]     addr_q, addr_d;
  logic                  ce1_n_q, ce1_n_d;
  logic                  ce2_q, ce2_d;
  logic                  we_n_q, we_n_d;
  logic                  oe_n_q, oe_n_d;
  logic [1:0]            lane_n_q, lane_n_d;
  logic [DATA_W-1:0]     dout_q, dout_d;
  logic                  doe_n_q, doe_n_d;
  logic                  rdy_q, rdy_d;
  logic                  rv_q, rv_d;
  logic [DATA_W-1:0]     rdata_q, rdata_d;
  logic [DATA_W-1:0]     rdata_cap;
  logic                  tmr_load;
  logic [TW-1:0]         tmr_cnt;
  logic                  tmr_done;

  asram_timer #(.W(TW)) u_timer (
    .clock  (clock),
    .arst_n (arst_n),
    .load   (tmr_load),
    .count  (tmr_cnt),
    .done   (tmr_done)
  );

  asram_lanes #(.LANES(2), .LW(`ASRAM_LANE_W)) u_lanes (
    .wdata     (dout_q),
    .lane_en   (~lane_n_q),
    .pin_in    (data_in),
    .rdata_old (rdata_q),
    .rdata_new (rdata_cap)
  );

  always_comb begin
    st_d     = st_q;
    addr_d   = addr_q;
    ce1_n_d  = ce1_n_q;
    ce2_d    = ce2_q;
    we_n_d   = we_n_q;
    oe_n_d   = oe_n_q;
    lane_n_d = lane_n_q;
    dout_d   = dout_q;
    doe_n_d  = doe_n_q;
    rdy_d    = rdy_q;
    rv_d     = 1'b0;
    rdata_d  = rdata_q;
    tmr_load = 1'b0;
    tmr_cnt  = '0;
    case (st_q)
      ASRAM_IDLE: begin
        if (!rdy_q) begin
          rdy_d = 1'b1;                     // Ready one cycle after reset
        end else if (req_valid && (req_lanes != 2'b00)) begin
          rdy_d    = 1'b0;
          addr_d   = req_addr;
          ce1_n_d  = 1'b0;
          ce2_d    = 1'b1;
          lane_n_d = ~req_lanes;
          if (req_write) begin
            oe_n_d  = 1'b1;
            dout_d  = req_wdata;
            doe_n_d = 1'b0;
            st_d    = ASRAM_WR_SETUP;
          end else begin
            we_n_d   = 1'b1;
            oe_n_d   = 1'b0;
            doe_n_d  = 1'b1;
            tmr_load = 1'b1;
            tmr_cnt  = TW'(RD_CYC);
            st_d     = ASRAM_RD_WAIT;
          end
        end
      end
      ASRAM_RD_WAIT: begin
        if (tmr_done) begin
          rdata_d = rdata_cap;
          st_d    = ASRAM_RD_DONE;
        end
      end
      ASRAM_RD_DONE: begin
        rv_d     = 1'b1;
        oe_n_d   = 1'b1;
        ce1_n_d  = 1'b1;
        ce2_d    = 1'b0;
        lane_n_d = 2'b11;
        tmr_load = 1'b1;
        tmr_cnt  = TW'(REC_CYC);
        st_d     = ASRAM_RECOVER;
      end
      ASRAM_WR_SETUP: begin
        we_n_d   = 1'b0;
        tmr_load = 1'b1;
        tmr_cnt  = TW'(WR_CYC);
        st_d     = ASRAM_WR_PULSE;
      end
      ASRAM_WR_PULSE: begin
        if (tmr_done) begin
          case (WR_END)
            ASRAM_END_CS: begin
              ce1_n_d = 1'b1;
              ce2_d   = 1'b0;
            end
            ASRAM_END_LANE: lane_n_d = 2'b11;
            default:        we_n_d   = 1'b1;
          endcase
          st_d = ASRAM_WR_END;
        end
      end
      ASRAM_WR_END: begin
        we_n_d   = 1'b1;                    // Data held through end edge
        ce1_n_d  = 1'b1;
        ce2_d    = 1'b0;
        lane_n_d = 2'b11;
        doe_n_d  = 1'b1;
        tmr_load = 1'b1;
        tmr_cnt  = TW'(REC_CYC);
        st_d     = ASRAM_RECOVER;
      end
      ASRAM_RECOVER: begin
        if (tmr_done) begin
          rdy_d = 1'b1;
          st_d  = ASRAM_IDLE;
        end
      end
      default: st_d = ASRAM_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_q     <= ASRAM_IDLE;
      addr_q   <= '0;
      ce1_n_q  <= 1'b1;
      ce2_q    <= 1'b0;
      we_n_q   <= 1'b1;
      oe_n_q   <= 1'b1;
      lane_n_q <= 2'b11;
      dout_q   <= '0;
      doe_n_q  <= 1'b1;
      rdy_q    <= 1'b0;
      rv_q     <= 1'b0;
      rdata_q  <= '0;
    end else begin
      st_q     <= st_d;
      addr_q   <= addr_d;
      ce1_n_q  <= ce1_n_d;
      ce2_q    <= ce2_d;
      we_n_q   <= we_n_d;
      oe_n_q   <= oe_n_d;
      lane_n_q <= lane_n_d;
      dout_q   <= dout_d;
      doe_n_q  <= doe_n_d;
      rdy_q    <= rdy_d;
      rv_q     <= rv_d;
      rdata_q  <= rdata_d;
    end
  end

  assign req_ready       = rdy_q;
  assign rsp_valid       = rv_q;
  assign rsp_rdata       = rdata_q;
  assign mem_addr        = addr_q;
  assign chip_en1_n      = ce1_n_q;
  assign chip_en2        = ce2_q;
  assign write_en_n      = we_n_q;
  assign out_en_n        = oe_n_q;
  assign upper_lane_en_n = lane_n_q[1];
  assign lower_lane_en_n = lane_n_q[0];
  assign data_out        = dout_q;
  assign data_oe_n       = doe_n_q;
endmodule // asram_host

/* File: rtl/asram_map.svh */
`ifndef ASRAM_MAP_SVH
`define ASRAM_MAP_SVH

// Pin timing in nanoseconds, fast grade
`define ASRAM_CLK_PERIOD_NS        10
`define ASRAM_ADDR_ACCESS_TIME_NS  45
`define ASRAM_ADDR_CHANGE_HOLD_NS  10
`define ASRAM_WRITE_STROBE_WIDTH_NS 35
`define ASRAM_ADDR_SETUP_WR_END_NS 35
`define ASRAM_WRITE_DATA_SETUP_NS  25
`define ASRAM_WRITE_FLOAT_DELAY_NS 18
`define ASRAM_DESELECT_STANDBY_NS  45
`define ASRAM_OE_FLOAT_DELAY_NS    18

// Widths
`define ASRAM_ADDR_W 18
`define ASRAM_DATA_W 16
`define ASRAM_LANE_W 8

`endif

/* File: rtl/asram_pkg.sv */
package asram_pkg;
  typedef enum logic [1:0] {
    ASRAM_END_WE,
    ASRAM_END_CS,
    ASRAM_END_LANE
  } asram_wr_end_e;

  typedef enum logic [2:0] {
    ASRAM_IDLE,
    ASRAM_RD_WAIT,
    ASRAM_RD_DONE,
    ASRAM_WR_SETUP,
    ASRAM_WR_PULSE,
    ASRAM_WR_END,
    ASRAM_RECOVER
  } asram_state_e;
endpackage

/* File: rtl/asram_timer.sv */
module asram_timer #(
  parameter int W = 4
) (
  input  wire logic         clock,
  input  wire logic         arst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              done
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = count;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign done = (cnt_q == '0) && !load;
endmodule // asram_timer

/* File: rtl/asram_lanes.sv */
// Per-lane read capture: enabled lanes take the pins, write data input is unused
module asram_lanes #(
  parameter int LANES = 2,
  parameter int LW    = 8
) (
  input  wire logic [LANES*LW-1:0] wdata,
  input  wire logic [LANES-1:0]    lane_en,
  input  wire logic [LANES*LW-1:0] pin_in,
  input  wire logic [LANES*LW-1:0] rdata_old,
  output logic [LANES*LW-1:0]      rdata_new
);
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    // Unused lanes keep their old value
    assign rdata_new[i*LW +: LW] = lane_en[i] ? pin_in[i*LW +: LW]
                                              : rdata_old[i*LW +: LW];
  end
  logic unused;
  assign unused = ^wdata;
endmodule // asram_lanes

/* File: testbench/asram_host_asserts.sv */
module asram_host_asserts (
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic        req_valid,
  input wire logic        req_write,
  input wire logic [1:0]  req_lanes,
  input wire logic        req_ready,
  input wire logic        rsp_valid,
  input wire logic [17:0] mem_addr,
  input wire logic        chip_en1_n,
  input wire logic        chip_en2,
  input wire logic        write_en_n,
  input wire logic        out_en_n,
  input wire logic        upper_lane_en_n,
  input wire logic        lower_lane_en_n,
  input wire logic [15:0] data_out,
  input wire logic        data_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic sel;
  assign sel = !chip_en1_n && chip_en2 && !(upper_lane_en_n && lower_lane_en_n);
  chk_read_we_high: assert property (!out_en_n |-> write_en_n)
    else $error("write strobe during read");
  chk_no_contend: assert property (!data_oe_n |-> out_en_n)
    else $error("host drives bus while device may drive");
  chk_we_selected: assert property (!write_en_n |-> sel)
    else $error("write strobe outside select");
  chk_strobe_width: assert property ($fell(write_en_n) |-> !write_en_n [*5])
    else $error("write strobe too short");
  chk_wr_addr_hold: assert property (!write_en_n |-> $stable(mem_addr))
    else $error("address moved in write");
  chk_wr_data_hold: assert property (!write_en_n |-> !data_oe_n && $stable(data_out))
    else $error("write data not held");
  chk_sel_addr: assert property (sel && $past(sel) |-> $stable(mem_addr))
    else $error("address moved while selected");
  chk_read_answer: assert property (req_valid && req_ready && !req_write && req_lanes != 2'h0
    |-> ##9 rsp_valid)
    else $error("read answer late");
  cov_read: cover property (rsp_valid);
  cov_write: cover property ($fell(write_en_n));
  cov_half: cover property (!out_en_n && upper_lane_en_n && !lower_lane_en_n);
endmodule // asram_host_asserts

bind asram_host asram_host_asserts asram_host_asserts_inst (.clock, .arst_n, .req_valid,
  .req_write, .req_lanes, .req_ready, .rsp_valid, .mem_addr, .chip_en1_n, .chip_en2,
  .write_en_n, .out_en_n, .upper_lane_en_n, .lower_lane_en_n, .data_out, .data_oe_n);

/* File: testbench/asram_dev_model.sv */
module asram_dev_model (
  input wire logic        clock,
  input wire logic [17:0] mem_addr,
  input wire logic        chip_en1_n,
  input wire logic        chip_en2,
  input wire logic        write_en_n,
  input wire logic        out_en_n,
  input wire logic        upper_lane_en_n,
  input wire logic        lower_lane_en_n,
  input wire logic [15:0] data_out,
  input wire logic        data_oe_n,
  output logic [15:0]     data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:262143];
  logic [7:0]  junk_q = 8'h5A;
  logic        sel;
  logic        rd;
  assign sel = !chip_en1_n && chip_en2 && !(upper_lane_en_n && lower_lane_en_n);
  assign rd  = sel && write_en_n && !out_en_n;
  // Floating lanes show a moving pattern, never the last value
  assign data_in[15:8] = !data_oe_n ? data_out[15:8] :
    (rd && !upper_lane_en_n) ? mem[mem_addr][15:8] : junk_q;
  assign data_in[7:0] = !data_oe_n ? data_out[7:0] :
    (rd && !lower_lane_en_n) ? mem[mem_addr][7:0] : ~junk_q;
  always @(posedge clock) begin
    junk_q <= junk_q + 8'h3B;
    if (sel && !write_en_n) begin
      if (!upper_lane_en_n) mem[mem_addr][15:8] <= data_in[15:8];
      if (!lower_lane_en_n) mem[mem_addr][7:0] <= data_in[7:0];
    end
  end
endmodule // asram_dev_model

/* File: testbench/tb_async_sram_16bit_port.sv */
module tb_async_sram_16bit_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic [17:0] req_addr = 18'h0;
  logic [15:0] req_wdata = 16'h0;
  logic [1:0]  req_lanes = 2'h0;
  logic        req_ready, rsp_valid, ce1_n, ce2, we_n, oe_n, up_n, lo_n, doe_n;
  logic [15:0] rsp_rdata, dout, din;
  logic [17:0] maddr;
  int          fails = 0;
  int          num_checks = 0;
  always #5 clock = ~clock;
  asram_host asram_host_inst (.clock(clock), .arst_n(arst_n), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_lanes(req_lanes),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_addr(maddr),
    .chip_en1_n(ce1_n), .chip_en2(ce2), .write_en_n(we_n), .out_en_n(oe_n),
    .upper_lane_en_n(up_n), .lower_lane_en_n(lo_n), .data_out(dout), .data_oe_n(doe_n),
    .data_in(din));
  asram_dev_model asram_dev_model_inst (.clock(clock), .mem_addr(maddr), .chip_en1_n(ce1_n),
    .chip_en2(ce2), .write_en_n(we_n), .out_en_n(oe_n), .upper_lane_en_n(up_n),
    .lower_lane_en_n(lo_n), .data_out(dout), .data_oe_n(doe_n), .data_in(din));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wait_neg(input logic sig_is_rsp);
    int n;
    n = 0;
    while ((sig_is_rsp ? rsp_valid : req_ready) !== 1'b1) begin
      @(negedge clock);
      n++;
      if (n > 40) begin
        fails++;
        wrap_up();
      end
    end
  endtask
  task automatic send(input logic wr, input logic [17:0] a, input logic [15:0] d,
                      input logic [1:0] ln);
    @(negedge clock);
    wait_neg(1'b0);
    req_valid = 1'b1;
    req_write = wr;
    req_addr  = a;
    req_wdata = d;
    req_lanes = ln;
    @(negedge clock);
    req_valid = 1'b0;
  endtask
  task automatic read_chk(input logic [17:0] a, input logic [1:0] ln, input logic [15:0] exp);
    send(1'b0, a, 16'h0, ln);
    wait_neg(1'b1);
    check("read data", rsp_rdata, exp);
  endtask
  task automatic sc_word;
    send(1'b1, 18'h3FFFF, 16'hA55A, 2'h3);
    read_chk(18'h3FFFF, 2'h3, 16'hA55A);
  endtask
  task automatic sc_lane_write;
    send(1'b1, 18'h00001, 16'h1234, 2'h3);
    send(1'b1, 18'h00001, 16'hABCD, 2'h1);
    read_chk(18'h00001, 2'h3, 16'h12CD);
  endtask
  task automatic sc_lane_read;
    // Upper lane only: lower half of the answer keeps the last read
    read_chk(18'h3FFFF, 2'h2, 16'hA5CD);
  endtask
  task automatic sc_no_lanes;
    int sel_cycles;
    sel_cycles = 0;
    send(1'b1, 18'h00001, 16'hFFFF, 2'h0);
    repeat (12) begin
      @(negedge clock);
      if (ce1_n !== 1'b1 || we_n !== 1'b1) sel_cycles++;
    end
    check("ignored request pins", 16'(sel_cycles), 16'h0);
    read_chk(18'h00001, 2'h3, 16'h12CD);
  endtask
  initial begin
    repeat (4) @(negedge clock);
    check("reset pins", {8'h0, ce1_n, ce2, we_n, oe_n, up_n, lo_n, doe_n, req_ready},
          16'h00BE);
    arst_n = 1'b1;
    sc_word();
    sc_lane_write();
    sc_lane_read();
    sc_no_lanes();
    wrap_up();
  end
endmodule // tb_async_sram_16bit_port
